// [hw/bcr_regs.sv]
// configuration register bank of a step-down converter, serial slave
// assumes scl/sda/en/pg/fault pins asynchronous; rst is power-on reset
`include "bcr_consts.svh"
`default_nettype none
module bcr_regs
  import bcr_pkg::*;
#(
  parameter int        HALF_MS_CYC = `BCR_HALF_MS_CYC,
  parameter logic [7:0] FACT_SET1  = `BCR_FACT_SET1,
  parameter logic [7:0] FACT_SET2  = `BCR_FACT_SET2,
  parameter logic [7:0] FACT_OUTPUT_VOLTAGE_CODE_REG  = `BCR_FACT_OUTPUT_VOLTAGE_CODE_REG
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic en_pin,
  input  wire logic pg_pin,
  input  wire bcr_fault_t fault_in,
  output bcr_ctrl_t ctrl,
  output logic      power_on,
  output logic [2:0] fault_flags
);
  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [12:0] output_voltage_code_reg_of(input logic [7:0] c);
    if (c <= `BCR_VR0_TOP) return 13'h0280 + 13'(c) * 13'h0005;
    if (c <= `BCR_VR1_TOP) return 13'h050A + 13'(c - 8'h81) * 13'h000A;
    if (c <= `BCR_VR2_TOP) return 13'h07BC + 13'(c - 8'hC4) * 13'h001E;
    return 13'h128E + 13'(c - 8'hF5) * 13'h0032;
  endfunction
  function automatic logic [10:0] khz_of(input logic [2:0] c);
    logic [10:0] r;
    r = 11'h000;
    unique case (c)
      3'h0: r = 11'h136;
      3'h1: r = 11'h190;
      3'h2: r = 11'h1F4;
      3'h3: r = 11'h23A;
      3'h4: r = 11'h294;
      3'h5: r = 11'h30C;
      3'h6: r = 11'h3CA;
      3'h7: r = 11'h4B0;
    endcase
    return r;
  endfunction
  function automatic logic [10:0] ss_of(input logic [1:0] c);
    logic [10:0] r;
    r = 11'h000;
    unique case (c)
      2'h0: r = 11'h0A0;
      2'h1: r = 11'h17C;
      2'h2: r = 11'h2F8;
      2'h3: r = 11'h5DC;
    endcase
    return r;
  endfunction
  function automatic logic [4:0] dly_half_ms(input logic [2:0] c);
    logic [4:0] r;
    r = 5'h00;
    unique case (c)
      3'h0: r = 5'h00;
      3'h1: r = 5'h01;
      3'h2: r = 5'h02;
      3'h3: r = 5'h04;
      3'h4: r = 5'h08;
      3'h5: r = 5'h0C;
      3'h6: r = 5'h10;
      3'h7: r = 5'h14;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_s, sda_s, en_s, pg_s, oc_s, tsd_s, twr_s;
  logic       scl_q, sda_q, en_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      en_s  <= 2'h0;
      pg_s  <= 2'h0;
      oc_s  <= 2'h0;
      tsd_s <= 2'h0;
      twr_s <= 2'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      en_q  <= 1'b0;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      en_s  <= {en_s[0], en_pin};
      pg_s  <= {pg_s[0], pg_pin};
      oc_s  <= {oc_s[0], fault_in.over_current};
      tsd_s <= {tsd_s[0], fault_in.thermal_shutdown};
      twr_s <= {twr_s[0], fault_in.thermal_warning};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
      en_q  <= en_s[1];
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop, en_rise;
  assign scl_rise  = scl_s[1] & ~scl_q;
  assign scl_fall  = ~scl_s[1] & scl_q;
  assign bus_start = scl_s[1] & scl_q & sda_q & ~sda_s[1];
  assign bus_stop  = scl_s[1] & scl_q & ~sda_q & sda_s[1];
  assign en_rise   = en_s[1] & ~en_q;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [4:0] set1;
  logic [6:0] set2;
  logic [7:0] output_voltage_code_reg;
  logic [6:0] cmd_hi;
  logic       cmd_clr;
  logic       wr_fire;
  logic [7:0] ptr, shreg;
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] r;
    unique case (a)
      `BCR_REG_STATUS: r = {fault_flags, 1'b0, en_s[1], 1'b1, ~|fault_flags, pg_s[1]};
      `BCR_REG_SET1:   r = {set1, 3'h0};
      `BCR_REG_SET2:   r = {1'b0, set2};
      `BCR_REG_OUTPUT_VOLTAGE_CODE_REG:   r = output_voltage_code_reg;
      `BCR_REG_CMD:    r = {cmd_hi, cmd_clr};
      default:         r = 8'h00;
    endcase
    return r;
  endfunction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      set1 <= FACT_SET1[`BCR_ILIM_HI:`BCR_FREQ_LO];
      set2 <= {FACT_SET2[`BCR_SUD_HI:`BCR_SUD_LO], `BCR_MRG_POR,
               FACT_SET2[`BCR_SS_HI:`BCR_SS_LO]};
      output_voltage_code_reg <= FACT_OUTPUT_VOLTAGE_CODE_REG;
      cmd_hi <= 7'(`BCR_CMD_POR >> 1);
    end else if (wr_fire) begin
      unique case (ptr)
        `BCR_REG_SET1: set1 <= shreg[`BCR_ILIM_HI:`BCR_FREQ_LO];
        `BCR_REG_SET2: set2 <= shreg[`BCR_SUD_HI:`BCR_SS_LO];
        `BCR_REG_OUTPUT_VOLTAGE_CODE_REG: output_voltage_code_reg <= shreg;
        `BCR_REG_CMD:  cmd_hi <= shreg[7:1];
        default: ;
      endcase
    end
  end
  // clear command and latched flags
  always_ff @(posedge ref_clk) begin
    if (rst)
      cmd_clr <= 1'b0;
    else
      cmd_clr <= wr_fire && ptr == `BCR_REG_CMD && shreg[`BCR_CLEAR_FAULT_FLAGS];
  end
  always_ff @(posedge ref_clk) begin
    if (rst)
      fault_flags <= 3'h0;
    else
      fault_flags <= (fault_flags & ~{3{cmd_clr}}) | {oc_s[1], tsd_s[1], twr_s[1]};
  end

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= '0;
    end else begin
      {ctrl.current_limit_sel, ctrl.switching_rate_sel}                  <= set1;
      {ctrl.startup_delay_sel, ctrl.margin_sel, ctrl.softstart_rate_sel} <= set2;
      ctrl.output_voltage_code <= output_voltage_code_reg;
      ctrl.load_amps           <= 3'(set1[4:3]) + 3'h2;
      ctrl.switch_khz          <= khz_of(set1[2:0]);
      ctrl.margin_pct          <= set2[3] ? 4'sh5 : (set2[2] ? -4'sh5 : 4'sh0);
      ctrl.softstart_mv_per_ms <= ss_of(set2[1:0]);
      ctrl.output_voltage_code_reg_mv             <= output_voltage_code_reg_of(output_voltage_code_reg);
    end
  end

  // ----------------------------------------------------------------
  // start-up delay
  // ----------------------------------------------------------------
  logic [23:0] dly_cnt;
  logic        dly_run;
  always_ff @(posedge ref_clk) begin
    if (rst || !en_s[1]) begin
      dly_cnt  <= 24'h000000;
      dly_run  <= 1'b0;
      power_on <= 1'b0;
    end else if (en_rise) begin
      if (set2[6:4] == 3'h0) begin
        power_on <= 1'b1;
      end else begin
        dly_cnt <= 24'(int'(dly_half_ms(set2[6:4])) * HALF_MS_CYC - 1);
        dly_run <= 1'b1;
      end
    end else if (dly_run) begin
      if (dly_cnt == 24'h000000) begin
        dly_run  <= 1'b0;
        power_on <= 1'b1;
      end else begin
        dly_cnt <= dly_cnt - 24'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  bcr_state_t state, after;
  logic [3:0] bit_cnt;
  logic       wr_pend, nack;
  assign wr_fire = scl_fall && state == BCR_ACK && wr_pend;
  assign sda_out = 1'b0;
  assign sda_oe  = (state == BCR_ACK) || (state == BCR_RDATA && !shreg[7]);

  always_ff @(posedge ref_clk) begin
    if (rst || bus_stop) begin
      state   <= BCR_IDLE;
      after   <= BCR_IDLE;
      bit_cnt <= 4'h0;
      wr_pend <= 1'b0;
      nack    <= 1'b0;
    end else if (bus_start) begin
      state   <= BCR_ADDR;
      bit_cnt <= 4'h0;
      wr_pend <= 1'b0;
    end else if (scl_rise) begin
      if (state inside {BCR_ADDR, BCR_PTR, BCR_WDATA}) begin
        shreg   <= {shreg[6:0], sda_s[1]};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (state == BCR_RACK)
        nack <= sda_s[1];
    end else if (scl_fall) begin
      unique case (state)
        BCR_IDLE: ;
        BCR_ADDR, BCR_PTR, BCR_WDATA: begin
          if (bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            state   <= BCR_ACK;
            wr_pend <= (state == BCR_WDATA);
            if (state == BCR_ADDR) begin
              if (shreg[7:1] != `BCR_DEV_ADDR)
                state <= BCR_IDLE;
              after <= shreg[0] ? BCR_RDATA : BCR_PTR;
            end else begin
              if (state == BCR_PTR)
                ptr <= shreg;
              after <= BCR_WDATA;
            end
          end
        end
        BCR_ACK: begin
          wr_pend <= 1'b0;
          state   <= after;
          if (wr_pend)
            ptr <= ptr + 8'h01;
          if (after == BCR_RDATA) begin
            shreg <= rd_mux(ptr);
            ptr   <= ptr + 8'h01;
          end
        end
        BCR_RDATA: begin
          shreg   <= {shreg[6:0], 1'b0};
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'h7) begin
            bit_cnt <= 4'h0;
            state   <= BCR_RACK;
          end
        end
        BCR_RACK: begin
          if (nack) begin
            state <= BCR_IDLE;
          end else begin
            state <= BCR_RDATA;
            shreg <= rd_mux(ptr);
            ptr   <= ptr + 8'h01;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  limit_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
    set1[4:3] == 2'h3 |=> ctrl.load_amps == 3'h5) else $error("load class wrong");
  rate_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
    set1[2:0] == 3'h7 |=> ctrl.switch_khz == 11'h4B0) else $error("rate wrong");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_mux(`BCR_REG_SET1) == {set1, 3'h0} && rd_mux(`BCR_REG_SET2) <= 8'h7F)
    else $error("reserved bit not zero");
  por_default_a: assert property (@(posedge ref_clk)
    rst |=> output_voltage_code_reg == FACT_OUTPUT_VOLTAGE_CODE_REG && set2[3:2] == `BCR_MRG_POR) else $error("bad defaults");
  startup_now_a: assert property (@(posedge ref_clk) disable iff (rst)
    en_rise && set2[6:4] == 3'h0 |=> power_on) else $error("no immediate start");
  startup_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
    en_rise && set2[6:4] != 3'h0 |=> !power_on [*2]) else $error("start too early");
  margin_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
    set2[3:2] == 2'h1 |=> ctrl.margin_pct == -4'sh5) else $error("margin wrong");
  soft_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
    set2[1:0] == 2'h3 |=> ctrl.softstart_mv_per_ms == 11'h5DC) else $error("slope wrong");
  output_voltage_code_reg_map_a: assert property (@(posedge ref_clk) disable iff (rst)
    output_voltage_code_reg == 8'hC4 |=> ctrl.output_voltage_code_reg_mv == 13'h07BC) else $error("output_voltage_code_reg map wrong");
  clear_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_clr |=> !cmd_clr ##0 (fault_flags == ($past({oc_s[1], tsd_s[1], twr_s[1]}))))
    else $error("clear did not act");
  flag_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    fault_flags[2] && !cmd_clr |=> fault_flags[2]) else $error("flag lost");
  enable_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_fire |=> $stable(set1) && $stable(output_voltage_code_reg)) else $error("registers changed");
endmodule
`default_nettype wire

// [include/bcr_consts.svh]
// constants of the converter configuration register bank
// assumes a 10 MHz reference clock
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BCR_REG_STATUS   8'h00
`define BCR_REG_SET1     8'h01
`define BCR_REG_SET2     8'h02
`define BCR_REG_OUTPUT_VOLTAGE_CODE_REG     8'h03
`define BCR_REG_CMD      8'h04
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BCR_ILIM_HI      7
`define BCR_ILIM_LO      6
`define BCR_FREQ_HI      5
`define BCR_FREQ_LO      3
`define BCR_SUD_HI       6
`define BCR_SUD_LO       4
`define BCR_MRG_HI       3
`define BCR_MRG_LO       2
`define BCR_SS_HI        1
`define BCR_SS_LO        0
`define BCR_CLEAR_FAULT_FLAGS         0
// ----------------------------------------------------------------
// factory defaults (plain values)
// ----------------------------------------------------------------
`define BCR_FACT_SET1    8'h00
`define BCR_FACT_SET2    8'h00
`define BCR_FACT_OUTPUT_VOLTAGE_CODE_REG    8'h00
`define BCR_MRG_POR      2'h0
`define BCR_CMD_POR      8'h00
// arbitrary bus address
`define BCR_DEV_ADDR     7'h50
// ----------------------------------------------------------------
// output voltage ranges
// ----------------------------------------------------------------
`define BCR_VR0_TOP      8'h80
`define BCR_VR1_TOP      8'hC3
`define BCR_VR2_TOP      8'hF4
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BCR_CLK_NS       100
`define BCR_HALF_MS_NS   500000
`define BCR_HALF_MS_CYC  (`BCR_HALF_MS_NS / `BCR_CLK_NS)
`endif

// [include/bcr_pkg.sv]
// types of the converter configuration register bank
// assumes nothing beyond the constants header
`default_nettype none
package bcr_pkg;
  // serial slave states
  typedef enum logic [6:0] {
    BCR_IDLE  = 7'h01,
    BCR_ADDR  = 7'h02,
    BCR_PTR   = 7'h04,
    BCR_WDATA = 7'h08,
    BCR_ACK   = 7'h10,
    BCR_RDATA = 7'h20,
    BCR_RACK  = 7'h40
  } bcr_state_t;

  // decoded controls for the power stage
  typedef struct packed {
    logic [1:0]  current_limit_sel;
    logic [2:0]  switching_rate_sel;
    logic [2:0]  startup_delay_sel;
    logic [1:0]  margin_sel;
    logic [1:0]  softstart_rate_sel;
    logic [7:0]  output_voltage_code;
    logic [2:0]  load_amps;
    logic [10:0] switch_khz;
    logic signed [3:0] margin_pct;
    logic [10:0] softstart_mv_per_ms;
    logic [12:0] output_voltage_code_reg_mv;
  } bcr_ctrl_t;

  // fault event inputs
  typedef struct packed {
    logic over_current;
    logic thermal_shutdown;
    logic thermal_warning;
  } bcr_fault_t;
endpackage
`default_nettype wire

// [verification/bcr_host.sv]
// serial bus host model writing and reading the register bank
// assumes a pull-up on the data line resolved by the bench
`include "bcr_consts.svh"
`default_nettype none
module bcr_host (
  input  wire logic  ref_clk,
  input  wire logic  sda_line,
  input  wire logic  slow,
  output logic       scl,
  output logic       sda_low,
  output logic [7:0] rd_byte,
  output logic       rd_pulse,
  output logic [7:0] nacks
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_byte = 8'h00;
    rd_pulse = 1'b0;
    nacks = 8'h00;
  end
  // third of a bit, long when slow
  task automatic tk();
    repeat (slow ? 9 : 5) @(negedge ref_clk);
  endtask
  // data changes only while the clock is low
  task automatic clk_bit(input logic b, output logic s);
    tk();
    sda_low = !b;
    tk();
    scl = 1'b1;
    tk();
    s = sda_line;
    scl = 1'b0;
  endtask
  task automatic start();
    tk();
    sda_low = 1'b0;
    tk();
    scl = 1'b1;
    tk();
    sda_low = 1'b1;
    tk();
    scl = 1'b0;
  endtask
  task automatic stop();
    tk();
    sda_low = 1'b1;
    tk();
    scl = 1'b1;
    tk();
    sda_low = 1'b0;
    tk();
  endtask
  task automatic byte_out(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    if (s) nacks = nacks + 8'h01;
  endtask
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
    start();
    byte_out({`BCR_DEV_ADDR, 1'b0});
    byte_out(p);
    byte_out(d);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] p);
    logic s;
    start();
    byte_out({`BCR_DEV_ADDR, 1'b0});
    byte_out(p);
    start();
    byte_out({`BCR_DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, rd_byte[i]);
    clk_bit(1'b1, s);
    stop();
    rd_pulse = 1'b1;
    @(negedge ref_clk);
    rd_pulse = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench of the converter register bank
// assumes the host model and a pull-up on the data line
`include "bcr_consts.svh"
`default_nettype none
module tb_top
  import bcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string n; logic [15:0] v;} bcr_note_t;
  localparam logic [10:0] KHZ [8] = '{11'h136, 11'h190, 11'h1F4, 11'h23A,
                                      11'h294, 11'h30C, 11'h3CA, 11'h4B0};
  localparam logic [10:0] SSR [4] = '{11'h0A0, 11'h17C, 11'h2F8, 11'h5DC};
  localparam logic [3:0]  MRG [4] = '{4'h0, 4'hB, 4'h5, 4'h5};
  localparam int          HMS [8] = '{0, 1, 2, 4, 8, 12, 16, 20};
  localparam logic [7:0]  VC  [8] = '{8'h00, 8'h80, 8'h81, 8'hC3,
                                      8'hC4, 8'hF4, 8'hF5, 8'hFF};
  logic        ref_clk, rst, en_pin, pg_pin, smp, slow;
  logic        sda_out, sda_oe, power_on, scl, sda_low, rd_pulse;
  bcr_fault_t  fault_in;
  bcr_ctrl_t   ctrl;
  logic [2:0]  fault_flags;
  logic [7:0]  rd_byte, nacks, d;
  logic [15:0] obs, got;
  int          errors, n_tests, cnt;
  bcr_note_t   q[$];
  bcr_note_t   cur;
  wire logic   sda_line = !(sda_low || (sda_oe && !sda_out));
  bcr_regs #(.HALF_MS_CYC(4)) u_dut (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .en_pin(en_pin),
    .pg_pin(pg_pin), .fault_in(fault_in), .ctrl(ctrl), .power_on(power_on),
    .fault_flags(fault_flags));
  bcr_host u_host (.ref_clk(ref_clk), .sda_line(sda_line), .slow(slow), .scl(scl),
    .sda_low(sda_low), .rd_byte(rd_byte), .rd_pulse(rd_pulse), .nacks(nacks));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic logic [12:0] mv(input logic [7:0] c);
    if (c <= 8'h80) return 13'h280 + 13'(c) * 13'h5;
    if (c <= 8'hC3) return 13'h50A + 13'(c - 8'h81) * 13'hA;
    if (c <= 8'hF4) return 13'h7BC + 13'(c - 8'hC4) * 13'h1E;
    return 13'h128E + 13'(c - 8'hF5) * 13'h32;
  endfunction
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    cmp("host acks", 16'h0000, 16'(nacks));
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] p, input string n, input logic [7:0] e);
    q.push_back('{n, {8'h00, e}});
    u_host.read_reg(p);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    q.push_back('{n, e});
    obs = g;
    smp = 1'b1;
    @(negedge ref_clk);
    smp = 1'b0;
    @(negedge ref_clk);
  endtask
  // results are matched against the oldest note
  always @(posedge ref_clk) begin
    if (rd_pulse || smp) begin
      got = smp ? obs : {8'h00, rd_byte};
      if (q.size() == 0) begin
        cmp("note queue", 16'h0001, 16'h0000);
      end else begin
        cur = q.pop_front();
        cmp(cur.n, cur.v, got);
      end
    end
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    errors++;
    $display("run limit reached");
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    en_pin = 1'b0;
    pg_pin = 1'b1;
    fault_in = '0;
    smp = 1'b0;
    slow = 1'b0;
    obs = 16'h0000;
    errors = 0;
    n_tests = 0;
    void'($urandom(65));
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    rd(`BCR_REG_SET1, "set1 default", `BCR_FACT_SET1);
    rd(`BCR_REG_SET2, "set2 default", `BCR_FACT_SET2);
    rd(`BCR_REG_OUTPUT_VOLTAGE_CODE_REG, "output_voltage_code_reg default", `BCR_FACT_OUTPUT_VOLTAGE_CODE_REG);
    rd(`BCR_REG_CMD, "cmd default", 8'h00);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      d = {i[1:0], i[2:0], 3'h7};
      u_host.write_reg(`BCR_REG_SET1, d);
      chk("load amps", 16'h2 + 16'(i[1:0]), 16'(ctrl.load_amps));
      chk("switch khz", 16'(KHZ[i]), 16'(ctrl.switch_khz));
      chk("limit sel", 16'(i[1:0]), 16'(ctrl.current_limit_sel));
      chk("rate sel", 16'(i[2:0]), 16'(ctrl.switching_rate_sel));
      rd(`BCR_REG_SET1, "set1 readback", d & 8'hF8);
      d = {1'b1, i[2:0], i[1:0], i[2:1]};
      u_host.write_reg(`BCR_REG_SET2, d);
      chk("margin pct", 16'(MRG[i[1:0]]), 16'($unsigned(ctrl.margin_pct)));
      chk("ramp slope", 16'(SSR[i[2:1]]), 16'(ctrl.softstart_mv_per_ms));
      chk("delay sel", 16'(i[2:0]), 16'(ctrl.startup_delay_sel));
      chk("margin sel", 16'(i[1:0]), 16'(ctrl.margin_sel));
      chk("ramp sel", 16'(i[2:1]), 16'(ctrl.softstart_rate_sel));
      rd(`BCR_REG_SET2, "set2 readback", d & 8'h7F);
    end
    $display("test setting fields done");
    for (int i = 0; i < 8; i++) begin
      en_pin = 1'b0;
      repeat (4) @(negedge ref_clk);
      u_host.write_reg(`BCR_REG_SET2, {1'b0, i[2:0], 4'h0});
      en_pin = 1'b1;
      cnt = 0;
      while (power_on !== 1'b1 && cnt < 300) begin
        @(negedge ref_clk);
        cnt++;
      end
      if (cnt >= 300) begin
        errors++;
        tally_and_finish();
      end
      chk("startup window", 16'h1, 16'(cnt >= HMS[i] * 4 + 3 && cnt <= HMS[i] * 4 + 5));
    end
    u_host.write_reg(`BCR_REG_SET2, 8'h77);
    chk("margin live", 16'(MRG[1]), 16'($unsigned(ctrl.margin_pct)));
    u_host.write_reg(`BCR_REG_OUTPUT_VOLTAGE_CODE_REG, 8'h11);
    chk("output_voltage_code_reg live", 16'(mv(8'h11)), 16'(ctrl.output_voltage_code_reg_mv));
    rd(`BCR_REG_SET1, "set1 kept", 8'hF8);
    en_pin = 1'b0;
    $display("test startup done");
    for (int k = 0; k < 10; k++) begin
      slow = (k < 3);
      d = (k < 8) ? VC[k] : 8'($urandom);
      u_host.write_reg(`BCR_REG_OUTPUT_VOLTAGE_CODE_REG, d);
      chk("output_voltage_code_reg mv", 16'(mv(d)), 16'(ctrl.output_voltage_code_reg_mv));
      chk("output_voltage_code_reg code", 16'(d), 16'(ctrl.output_voltage_code));
      rd(`BCR_REG_OUTPUT_VOLTAGE_CODE_REG, "output_voltage_code_reg readback", d);
    end
    u_host.write_reg(8'h07, 8'h5A);
    rd(8'h07, "unmapped read", 8'h00);
    $display("test output code done");
    for (int i = 0; i < 3; i++) begin
      fault_in = bcr_fault_t'(3'h1 << i);
      repeat (6) @(negedge ref_clk);
      fault_in = '0;
      repeat (6) @(negedge ref_clk);
      chk("latched flags", 16'((4'h2 << i) - 4'h1), 16'(fault_flags));
    end
    rd(`BCR_REG_STATUS, "status", {3'h7, 1'b0, en_pin, 1'b1, 1'b0, pg_pin});
    u_host.write_reg(`BCR_REG_CMD, 8'hFE);
    chk("upper cmd bits", 16'h7, 16'(fault_flags));
    u_host.write_reg(`BCR_REG_CMD, 8'h01);
    chk("flags cleared", 16'h0, 16'(fault_flags));
    rd(`BCR_REG_CMD, "clear bit", 8'h00);
    $display("test faults done");
    u_host.write_reg(`BCR_REG_SET1, 8'hA8);
    rst = 1'b1;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    rd(`BCR_REG_SET1, "set1 after reset", `BCR_FACT_SET1);
    rd(`BCR_REG_SET2, "set2 after reset", `BCR_FACT_SET2);
    $display("test reset done");
    repeat (4) @(negedge ref_clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
